/* src/sdirx_pins_if.sv */
// Interface: synchronised pin levels and their edges
`default_nettype none
interface sdirx_pins_if;
  import sdirx_pkg::*;
  logic [PIN_CNT-1:0] level;
  logic [PIN_CNT-1:0] rise;
  logic [PIN_CNT-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : sdirx_pins_if
`default_nettype wire

/* src/sdirx_pkg.sv */
// Package: constants, register map and selector codes for the parallel output port
`default_nettype none
package sdirx_pkg;

  // ==========================================================
  // Data path and memory shape
  localparam int unsigned WORD_W      = 10;
  localparam int unsigned MEM_AW      = 4;
  localparam int unsigned MEM_DEPTH   = 16;
  localparam int unsigned PIN_CNT     = 6;

  // ==========================================================
  // Synchronised pin indices
  localparam int unsigned PIN_RD_CLK  = 0;
  localparam int unsigned PIN_RD_RST  = 1;
  localparam int unsigned PIN_ASI     = 2;
  localparam int unsigned PIN_SVM     = 3;
  localparam int unsigned PIN_AUTO    = 4;
  localparam int unsigned PIN_FIFO_EN = 5;

  // ==========================================================
  // Pixel rate generation from the system clock
  localparam int unsigned CLK_RATE_KHZ   = 40000;
  localparam int unsigned PIXEL_RATE_KHZ = 27000;
  localparam logic [6:0]  PHASE_STEP     = 7'(PIXEL_RATE_KHZ / 1000);
  localparam logic [6:0]  PHASE_WRAP     = 7'(CLK_RATE_KHZ / 1000);
  // Start so the first step hits; no two empty slots ever follow reset
  localparam logic [6:0]  PHASE_RESET    = 7'h0D;

  // ==========================================================
  // Register byte offsets
  localparam logic [3:0] OFF_OUT_SEL = 4'h0;
  localparam logic [3:0] OFF_CTRL    = 4'h4;
  localparam logic [3:0] OFF_STATUS  = 4'h8;

  // ==========================================================
  // Status output selector codes, one 3-bit field per output
  localparam int unsigned SEL_W       = 3;
  localparam logic [2:0] SEL_H        = 3'h0;
  localparam logic [2:0] SEL_V        = 3'h1;
  localparam logic [2:0] SEL_F        = 3'h2;
  localparam logic [2:0] SEL_LOAD     = 3'h3;
  localparam logic [2:0] SEL_ANC      = 3'h4;
  localparam logic [2:0] SEL_ERRPKT   = 3'h5;
  localparam logic [2:0] SEL_FULL     = 3'h6;
  localparam logic [2:0] SEL_EMPTY    = 3'h7;
  localparam logic [11:0] OUT_SEL_RESET = {SEL_LOAD, SEL_F, SEL_V, SEL_H};

  // ==========================================================
  // Memory operating modes held in the control register
  localparam logic [1:0] FMODE_VIDEO  = 2'h0;
  localparam logic [1:0] FMODE_ASI    = 2'h1;
  localparam logic [1:0] FMODE_ANC    = 2'h2;
  localparam logic [1:0] FMODE_PKT    = 2'h3;
  localparam logic [1:0] CTRL_RESET   = FMODE_VIDEO;

endpackage : sdirx_pkg
`default_nettype wire

/* src/sdirx_port.sv */
// Parallel output port of the serial video / ASI receiver
//
// Contract
// - Each status output shows the signal chosen by its own selector field.
// - Application supplies read clock; data advances on each read clock rise.
// - Read reset acts only in serial-video mode with memory in video mode.
// - Read reset falling edge, seen at read clock, zeroes the read pointer.
// - Memory enabled in video or ASI mode: output updates on read clock.
// - Bypass: output updates on the pixel clock instead of read clock.
// - Output bus is ten bits, bit 9 most significant.
// - Drive a 27 MHz pixel clock alongside the output data; pixel_clk here is a strobe high 27 of every 40 system clocks.
// - Lock indicator high when locked to compliant data, else low.
// - While lock is low, all data and status outputs are forced low.
// - ASI pin: input in manual, driven output in auto; other side releases.
// - Auto mode: ASI pin high only while locked to an ASI stream.
// - Manual, ASI pin high: ASI mode, serial-video pin ignored.
// - Manual, ASI pin low: no ASI alignment or decoding.
// - Auto select high drives both mode pins; low makes both inputs.
// - Memory enable high uses memory; low bypasses it on pixel timing.
// - Auto mode: serial-video pin high only while locked to video stream.
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`default_nettype none
module sdirx_port
  import sdirx_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset_n,
  // Avalon-MM register slave
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // Upstream receiver stream and status, same clock
  input  wire logic [WORD_W-1:0] in_word,
  input  wire logic              in_valid,
  input  wire logic              in_h,
  input  wire logic              in_v,
  input  wire logic              in_f,
  input  wire logic              in_fifo_load_marker,
  input  wire logic              in_ancillary_found,
  input  wire logic              in_error_packet_found,
  input  wire logic              lock_in,
  input  wire logic              asi_stream_seen,
  input  wire logic              sdi_stream_seen,
  // Pins from the application
  input  wire logic              rd_clk,
  input  wire logic              rd_reset,
  input  wire logic              auto_manual_select,
  input  wire logic              fifo_enable,
  // Mode pins, split into input, output and active-low enable
  input  wire logic              asi_mode_pin_i,
  output logic                   asi_mode_pin_o,
  output logic                   asi_mode_pin_oe_n,
  input  wire logic              serial_video_mode_pin_i,
  output logic                   serial_video_mode_pin_o,
  output logic                   serial_video_mode_pin_oe_n,
  // Parallel output
  output logic      [WORD_W-1:0] dout,
  output logic      [3:0]        stat,
  output logic                   pixel_clk,
  output logic                   locked,
  output logic                   asi_decode_en
);

  // ==========================================================
  // Pin synchronisation
  sdirx_pins_if pins ();

  sdirx_sync u_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .raw     ({fifo_enable, auto_manual_select, serial_video_mode_pin_i,
               asi_mode_pin_i, rd_reset, rd_clk}),
    .pins    (pins.src)
  );

  wire logic auto_mode  = pins.level[PIN_AUTO];
  wire logic fifo_on    = pins.level[PIN_FIFO_EN];
  wire logic rd_rise    = pins.rise[PIN_RD_CLK];
  wire logic asi_pin_lv = pins.level[PIN_ASI];
  wire logic svm_pin_lv = pins.level[PIN_SVM];

  // ==========================================================
  // Status selector helper
  function automatic logic pick_stat(input logic [2:0] sel, input logic [7:0] src);
    pick_stat = src[sel];
  endfunction : pick_stat

  // ==========================================================
  // Registers
  logic [11:0]         out_sel_q;
  logic [1:0]          fmode_q;
  logic                wait_q;
  logic [31:0]         rdata_q;
  logic [WORD_W-1:0]   mem [MEM_DEPTH];
  logic [MEM_AW:0]     wr_ptr_q;
  logic [MEM_AW:0]     rd_ptr_q;
  logic                rst_smp_q;
  logic [6:0]          phase_q;
  logic                pix_tick_q;
  logic [WORD_W-1:0]   dout_q;
  logic [3:0]          stat_q;
  logic                locked_q;
  logic                asi_o_q;
  logic                svm_o_q;
  logic                oe_n_q;
  logic                asi_dec_q;

  // ==========================================================
  // Operating mode resolution
  // Manual: ASI pin wins over the serial-video pin
  wire logic asi_mode = auto_mode ? asi_o_q : asi_pin_lv;
  wire logic svm_mode = auto_mode ? svm_o_q : (!asi_pin_lv && svm_pin_lv);
  wire logic asi_auto_d = auto_mode && lock_in && asi_stream_seen;
  wire logic svm_auto_d = auto_mode && lock_in && sdi_stream_seen;

  // ==========================================================
  // Memory flags and pointer control
  wire logic [MEM_AW:0] ptr_diff = wr_ptr_q - rd_ptr_q;
  wire logic mem_full   = ptr_diff[MEM_AW];
  wire logic mem_empty  = (ptr_diff == '0);
  wire logic mem_write  = fifo_on && in_valid && !mem_full;
  wire logic rd_advance = fifo_on && rd_rise && !mem_empty;
  // Falling edge of read reset as seen at a read clock rise
  wire logic rr_fall    = rd_rise && rst_smp_q && !pins.level[PIN_RD_RST];
  wire logic rr_valid   = svm_mode && !asi_mode && fifo_on
                          && (fmode_q == FMODE_VIDEO);

  // ==========================================================
  // Output update strobe: read clock with memory, pixel tick in bypass
  wire logic out_strobe = fifo_on ? rd_rise : pix_tick_q;
  wire logic [WORD_W-1:0] out_word = fifo_on ? mem[rd_ptr_q[MEM_AW-1:0]] : in_word;
  wire logic [7:0] stat_src = {mem_empty, mem_full, in_error_packet_found,
                               in_ancillary_found, in_fifo_load_marker, in_f, in_v, in_h};
  wire logic [3:0] stat_d;

  // One selector per status output
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_stat
      assign stat_d[gi] = pick_stat(out_sel_q[gi*SEL_W +: SEL_W], stat_src);
    end
  endgenerate

  // ==========================================================
  // Register bus decode
  wire logic bus_req   = avs_read || avs_write;
  wire logic bus_ack   = bus_req && !wait_q;
  wire logic wr_outsel = bus_ack && avs_write && (avs_address == OFF_OUT_SEL);
  wire logic wr_ctrl   = bus_ack && avs_write && (avs_address == OFF_CTRL);
  wire logic [31:0] rd_mux =
    (avs_address == OFF_OUT_SEL) ? {20'h00000, out_sel_q} :
    (avs_address == OFF_CTRL)    ? {30'h00000000, fmode_q} :
    (avs_address == OFF_STATUS)  ? {21'h000000, rd_ptr_q, mem_full, mem_empty,
                                    svm_mode, asi_mode, auto_mode, locked_q} :
                                   32'h00000000;

  // Waitrequest drops one cycle after a request; read data latched with it
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q  <= !(bus_req && wait_q);
      if (bus_req && wait_q) begin
        rdata_q <= avs_read ? rd_mux : 32'h00000000;
      end
    end
  end

  // Software settings, byte lanes respected
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      out_sel_q <= OUT_SEL_RESET;
      fmode_q   <= CTRL_RESET;
    end else begin
      if (wr_outsel && avs_byteenable[0]) out_sel_q[7:0]  <= avs_writedata[7:0];
      if (wr_outsel && avs_byteenable[1]) out_sel_q[11:8] <= avs_writedata[11:8];
      if (wr_ctrl && avs_byteenable[0])   fmode_q         <= avs_writedata[1:0];
    end
  end

  // ==========================================================
  // Pixel tick: phase accumulator averaging 27 ticks per 40 clocks
  // Limitation: a 40 MHz clock cannot toggle at 27 MHz, so this is a strobe
  wire logic [6:0] phase_sum = phase_q + PHASE_STEP;
  wire logic       phase_hit = (phase_sum >= PHASE_WRAP);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      phase_q    <= PHASE_RESET;
      pix_tick_q <= 1'b0;
    end else begin
      phase_q    <= phase_hit ? phase_sum - PHASE_WRAP : phase_sum;
      pix_tick_q <= phase_hit;
    end
  end

  // ==========================================================
  // Line memory write side; no reset needed on storage
  always_ff @(posedge clock) begin
    if (mem_write) begin
      mem[wr_ptr_q[MEM_AW-1:0]] <= in_word;
    end
  end

  // Pointers; read reset copies the write pointer's wrap bit so the fill count stays sane
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wr_ptr_q  <= '0;
      rd_ptr_q  <= '0;
      rst_smp_q <= 1'b0;
    end else begin
      if (mem_write) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (rd_rise) rst_smp_q <= pins.level[PIN_RD_RST];
      if (rr_fall && rr_valid) begin
        rd_ptr_q <= {wr_ptr_q[MEM_AW], {MEM_AW{1'b0}}};
      end else if (rd_advance) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // Output bus and status, forced low without lock
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      dout_q <= '0;
      stat_q <= 4'h0;
    end else if (!lock_in) begin
      dout_q <= '0;
      stat_q <= 4'h0;
    end else if (out_strobe) begin
      dout_q <= out_word;
      stat_q <= stat_d;
    end
  end

  // ==========================================================
  // Lock, mode pins and decoder enable
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      locked_q  <= 1'b0;
      asi_o_q   <= 1'b0;
      svm_o_q   <= 1'b0;
      oe_n_q    <= 1'b1;
      asi_dec_q <= 1'b0;
    end else begin
      locked_q  <= lock_in;
      asi_o_q   <= asi_auto_d;
      svm_o_q   <= svm_auto_d;
      oe_n_q    <= !auto_mode;
      asi_dec_q <= asi_mode;
    end
  end

  // Outputs straight from flops
  assign avs_readdata               = rdata_q;
  assign avs_waitrequest            = wait_q;
  assign dout                       = dout_q;
  assign stat                       = stat_q;
  assign pixel_clk                  = pix_tick_q;
  assign locked                     = locked_q;
  assign asi_mode_pin_o             = asi_o_q;
  assign asi_mode_pin_oe_n          = oe_n_q;
  assign serial_video_mode_pin_o    = svm_o_q;
  assign serial_video_mode_pin_oe_n = oe_n_q;
  assign asi_decode_en              = asi_dec_q;

  // ==========================================================
  // Assertions
  property p_unlock_low;
    @(posedge clock) disable iff (!reset_n)
    !lock_in |=> (dout_q == '0) && (stat_q == 4'h0);
  endproperty
  a_unlock_low: assert property (p_unlock_low) else $error("outputs not low without lock");

  property p_rd_reset;
    @(posedge clock) disable iff (!reset_n)
    (rr_fall && rr_valid) |=> (rd_ptr_q[MEM_AW-1:0] == '0);
  endproperty
  a_rd_reset: assert property (p_rd_reset) else $error("read pointer not zeroed");

  property p_rd_reset_ignored;
    @(posedge clock) disable iff (!reset_n)
    (rr_fall && !rr_valid && !rd_advance) |=> (rd_ptr_q == $past(rd_ptr_q));
  endproperty
  a_rd_reset_ignored: assert property (p_rd_reset_ignored) else $error("pointer moved");

  property p_bypass_data;
    @(posedge clock) disable iff (!reset_n)
    (!fifo_on && pix_tick_q && lock_in) |=> (dout_q == $past(in_word));
  endproperty
  a_bypass_data: assert property (p_bypass_data) else $error("bypass data wrong");

  property p_fifo_hold;
    @(posedge clock) disable iff (!reset_n)
    (fifo_on && !rd_rise && lock_in && $past(lock_in)) |=> $stable(dout_q);
  endproperty
  a_fifo_hold: assert property (p_fifo_hold) else $error("data moved without read clock");

  property p_pixel_rate;
    @(posedge clock) disable iff (!reset_n)
    !pix_tick_q ##1 !pix_tick_q |-> 1'b0;
  endproperty
  a_pixel_rate: assert property (p_pixel_rate) else $error("pixel tick gap too long");

  property p_auto_asi;
    @(posedge clock) disable iff (!reset_n)
    (auto_mode && !oe_n_q) |-> (asi_mode_pin_o == $past(lock_in && asi_stream_seen));
  endproperty
  a_auto_asi: assert property (p_auto_asi) else $error("auto ASI pin wrong");

  property p_manual_release;
    @(posedge clock) disable iff (!reset_n)
    !auto_mode ##1 !auto_mode |-> asi_mode_pin_oe_n && serial_video_mode_pin_oe_n;
  endproperty
  a_manual_release: assert property (p_manual_release) else $error("pin driven in manual");

  property p_manual_asi;
    @(posedge clock) disable iff (!reset_n)
    (!auto_mode && asi_pin_lv) |-> !svm_mode ##1 asi_decode_en;
  endproperty
  a_manual_asi: assert property (p_manual_asi) else $error("manual ASI mode wrong");

  property p_lock_follow;
    @(posedge clock) disable iff (!reset_n)
    ##1 1'b1 |-> (locked == $past(lock_in));
  endproperty
  a_lock_follow: assert property (p_lock_follow) else $error("lock indicator lags");

endmodule : sdirx_port
`default_nettype wire

/* src/sdirx_sync.sv */
// Two-stage pin synchroniser with edge detection
`default_nettype none
module sdirx_sync
  import sdirx_pkg::*;
(
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               reset_n,
  // Raw pins
  input  wire logic [PIN_CNT-1:0] raw,
  // Synchronised view
  sdirx_pins_if.src               pins
);

  logic [PIN_CNT-1:0] meta_q;
  logic [PIN_CNT-1:0] sync_q;
  logic [PIN_CNT-1:0] prev_q;

  // ==========================================================
  // First stage only feeds the second; edges come from later stages
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Level and one-cycle edge strobes
  assign pins.level = sync_q;
  assign pins.rise  = sync_q & ~prev_q;
  assign pins.fall  = ~sync_q & prev_q;

endmodule : sdirx_sync
`default_nettype wire

/* testbench/sdirx_app_model.sv */
// Application-side model: read clock, read reset and manual mode pins
`default_nettype none
module sdirx_app_model (
  // Read side
  output logic rd_clk,
  output logic rd_reset,
  // Mode pin drive, enables low while this side drives
  output logic asi_drv,
  output logic asi_oe_n,
  output logic svm_drv,
  output logic svm_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Idle levels: read clock stands still between reads
  initial begin
    rd_clk   = 1'b0;
    rd_reset = 1'b0;
    asi_drv  = 1'b0;
    asi_oe_n = 1'b1;
    svm_drv  = 1'b0;
    svm_oe_n = 1'b1;
  end

  // One 200 ns read clock period, free of the system clock phase
  task automatic read_word();
    rd_clk = 1'b1;
    #100;
    rd_clk = 1'b0;
    #100;
  endtask : read_word

  // High across one read clock rise, then low; the next rise sees the fall
  task automatic pulse_reset();
    rd_reset = 1'b1;
    read_word();
    rd_reset = 1'b0;
  endtask : pulse_reset

  // Manual pins; released before the device drives them in auto
  task automatic set_pins(input logic drive, input logic asi, input logic svm);
    asi_oe_n = !drive;
    svm_oe_n = !drive;
    asi_drv  = asi;
    svm_drv  = svm;
  endtask : set_pins
endmodule : sdirx_app_model
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the parallel output port
`default_nettype none
module testbench;
  import sdirx_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals
  logic clock = 1'b0, reset_n = 1'b0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [WORD_W-1:0] in_word = '0, dout, w;
  logic in_valid = 1'b0, lock_in = 1'b1, asi_seen = 1'b0, sdi_seen = 1'b0;
  logic [5:0] src_in = 6'h0;
  logic auto_sel = 1'b0, fifo_en = 1'b1;
  logic [3:0] stat;
  logic pixel_clk, locked, asi_decode_en, rd_clk, rd_reset;
  logic asi_o, asi_oe_n, svm_o, svm_oe_n, a_drv, a_oe_n, s_drv, s_oe_n;
  logic [7:0] src;
  int num_errors = 0, checks_done = 0, rd_idx = 0, n;
  int mem_q[$];

  // Pin levels; pull-up when nobody drives
  wire asi_pin = !asi_oe_n ? asi_o : (!a_oe_n ? a_drv : 1'b1);
  wire svm_pin = !svm_oe_n ? svm_o : (!s_oe_n ? s_drv : 1'b1);

  // 40 MHz system clock
  initial begin
    forever #12.5 clock = !clock;
  end

  sdirx_port dut_u (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .in_word(in_word), .in_valid(in_valid),
    .in_h(src_in[0]), .in_v(src_in[1]), .in_f(src_in[2]),
    .in_fifo_load_marker(src_in[3]), .in_ancillary_found(src_in[4]),
    .in_error_packet_found(src_in[5]), .lock_in(lock_in), .asi_stream_seen(asi_seen),
    .sdi_stream_seen(sdi_seen), .rd_clk(rd_clk), .rd_reset(rd_reset),
    .auto_manual_select(auto_sel), .fifo_enable(fifo_en), .asi_mode_pin_i(asi_pin),
    .asi_mode_pin_o(asi_o), .asi_mode_pin_oe_n(asi_oe_n),
    .serial_video_mode_pin_i(svm_pin), .serial_video_mode_pin_o(svm_o),
    .serial_video_mode_pin_oe_n(svm_oe_n), .dout(dout), .stat(stat),
    .pixel_clk(pixel_clk), .locked(locked), .asi_decode_en(asi_decode_en));

  sdirx_app_model app_u (.rd_clk(rd_clk), .rd_reset(rd_reset), .asi_drv(a_drv),
    .asi_oe_n(a_oe_n), .svm_drv(s_drv), .svm_oe_n(s_oe_n));

  // ==========================================================
  // Shared tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [31:0] exp);
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    if (!wr) chk("readdata", exp, avs_readdata);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  // Read one word and compare with the queue model
  task automatic read_chk();
    app_u.read_word();
    chk("dout", 32'(mem_q[rd_idx]), 32'(dout));
    rd_idx++;
  endtask : read_chk

  // Read reset pulse: one read with reset high, then the read that sees the fall
  task automatic reset_read(input bit honoured);
    app_u.pulse_reset();
    chk("dout", 32'(mem_q[rd_idx]), 32'(dout));
    rd_idx++;
    read_chk();
    if (honoured) rd_idx = 0;
  endtask : reset_read

  task automatic settle();
    repeat (8) @(posedge clock);
  endtask : settle

  task automatic conclude();
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // Watchdog, well beyond the expected run
  initial begin
    #2000000;
    num_errors++;
    conclude();
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(19));
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    settle();
    bus(1'b0, OFF_OUT_SEL, 32'h0, 32'h688);
    bus(1'b0, OFF_CTRL, 32'h0, 32'h0);
    bus(1'b0, 4'hC, 32'h0, 32'h0);
    bus(1'b0, OFF_STATUS, 32'h0, 32'h15);
    app_u.set_pins(1'b1, 1'b0, 1'b1);
    src_in <= 6'($urandom);
    settle();
    // Every selector code on all four outputs, memory still empty
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, OFF_OUT_SEL, 32'({4{3'(c)}}), 32'h0);
      app_u.read_word();
      src = {1'b1, 1'b0, src_in};
      chk("stat", 32'({4{src[c]}}), 32'(stat));
    end
    // Fill eight words, read three back in order
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      w = 10'($urandom);
      in_word  <= w;
      in_valid <= 1'b1;
      mem_q.push_back(int'(w));
    end
    @(posedge clock);
    in_valid <= 1'b0;
    repeat (3) read_chk();
    // Read reset honoured in serial-video with video memory mode
    reset_read(1'b1);
    read_chk();
    // Ignored in ASI memory mode
    bus(1'b1, OFF_CTRL, 32'(FMODE_ASI), 32'h0);
    bus(1'b0, OFF_CTRL, 32'h0, 32'(FMODE_ASI));
    reset_read(1'b0);
    read_chk();
    bus(1'b1, OFF_CTRL, 32'(FMODE_VIDEO), 32'h0);
    // Ignored when the ASI pin is high; serial-video pin then ignored
    app_u.set_pins(1'b1, 1'b1, 1'b1);
    settle();
    reset_read(1'b0);
    read_chk();
    chk("asi_decode_en", 32'h1, 32'(asi_decode_en));
    app_u.set_pins(1'b1, 1'b0, 1'b1);
    settle();
    chk("asi_decode_en", 32'h0, 32'(asi_decode_en));
    // Loss of lock forces outputs low
    lock_in <= 1'b0;
    settle();
    chk("dout", 32'h0, 32'(dout));
    chk("stat", 32'h0, 32'(stat));
    chk("locked", 32'h0, 32'(locked));
    lock_in <= 1'b1;
    settle();
    chk("locked", 32'h1, 32'(locked));
    // Bypass: data follows the pixel strobe
    fifo_en <= 1'b0;
    w = 10'($urandom);
    in_word <= w;
    repeat (12) @(posedge clock);
    chk("dout", 32'(w), 32'(dout));
    n = 0;
    repeat (400) begin
      @(posedge clock);
      if (pixel_clk === 1'b1) n++;
    end
    chk("pixel_clk", 32'd270, 32'(n));
    // Auto mode: application releases, device drives both pins
    app_u.set_pins(1'b0, 1'b0, 1'b0);
    auto_sel <= 1'b1;
    asi_seen <= 1'b1;
    settle();
    chk("pins", 32'h2, 32'({asi_oe_n, svm_oe_n, asi_o, svm_o}));
    asi_seen <= 1'b0;
    sdi_seen <= 1'b1;
    settle();
    chk("pins", 32'h1, 32'({asi_oe_n, svm_oe_n, asi_o, svm_o}));
    auto_sel <= 1'b0;
    settle();
    chk("oe_n", 32'h3, 32'({asi_oe_n, svm_oe_n}));
    conclude();
  end
endmodule : testbench
`default_nettype wire
